// ==== gwsl_loader.sv ====
// Constants package and serial gain word loader with power and transmit gating, AHB-Lite slave.
// Assumes the host drives link_sclk, gain_load_enable_n and serial_gain_data together;
// the system clock runs at 250 MHz and is unrelated to the serial clock.
//
// Contract
// - While the load enable is low, bits enter the shift register and the applied gain holds; here a gain register write still changes it.
// - On the load enable rising, the shifted word becomes the applied gain and shifting stops.
// - The gain word is eight bits long and arrives most significant bit first.
// - A rising serial clock edge with loading enabled captures the data bit into the master.
// - A falling serial clock edge moves the master bit on into the slave shift stage.
// - Sleep low powers the block down with a high-impedance output; high powers it up.
// - Transmit gate low stops forward transmission; high lets it run.
// - Only the six low bits of the word form the gain code; the two top bits are dropped.
// - Codes 1 to 60 are valid, and codes 61 to 63 act as code 60; here code 0 is not raised to 1 and is applied as 0.
// - Each step of one in the code raises the gain by one decibel, linearly.
//
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
package gwsl_pkg;
	localparam int         WORD_W        = 8;
	localparam int         CODE_W        = 6;
	localparam int         CNT_W         = 16;
	localparam int         PIN_W         = 3;
	localparam logic [5:0] CODE_MIN      = 6'h01;
	localparam logic [5:0] CODE_MAX      = 6'h3c;
	localparam logic [5:0] CODE_RESET    = 6'h01;
	localparam logic [7:0] HALF_DB_BASE  = 8'h35;
	localparam logic [7:0] HALF_DB_RESET = 8'hcd;
	localparam logic [7:0] WORD_RESET    = 8'h00;
	localparam logic [7:0] ADDR_GAIN     = 8'h00;
	localparam logic [7:0] ADDR_STATUS   = 8'h04;
	localparam logic [7:0] ADDR_COUNT    = 8'h08;
	localparam int         ADDR_LSB      = 2;
	localparam int         ADDR_MSB      = 7;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
	localparam logic [31:0] DATA_ZERO    = 32'h0000_0000;
	localparam int         ST_CODE_LSB   = 0;
	localparam int         ST_WORD_LSB   = 8;
	localparam int         ST_POWERED    = 16;
	localparam int         ST_TX         = 17;
	localparam int         ST_LOADING    = 18;
	localparam int         PIN_LOAD      = 0;
	localparam int         PIN_SLEEP     = 1;
	localparam int         PIN_TXGATE    = 2;
	localparam logic [2:0] PIN_RESET     = 3'h7;
endpackage

module gwsl_loader (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        link_sclk,
	input  wire logic        gain_load_enable_n,
	input  wire logic        serial_gain_data,
	input  wire logic        sleep_n,
	input  wire logic        transmit_gate,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic      [5:0]  gain_code,
	output logic      [7:0]  gain_half_db,
	output logic             out_hiz,
	output logic             powered_up,
	output logic             tx_active
);

	// Reduce a shifted word to an applied gain code
	function automatic logic [5:0] clamp_code(input logic [7:0] word);
		logic [5:0] low;
		low = word[gwsl_pkg::CODE_W-1:0];
		if (low > gwsl_pkg::CODE_MAX) begin
			return gwsl_pkg::CODE_MAX;
		end
		return low;
	endfunction

	// Gain in half-decibel units; the minimum code sits at -25.5 dB
	function automatic logic [7:0] half_db(input logic [5:0] code);
		logic [7:0] twice;
		twice = {1'b0, code, 1'b0};
		return 8'(twice - gwsl_pkg::HALF_DB_BASE);
	endfunction

	// Serial clock domain: master on rise, slave shift on fall
	typedef struct packed {
		logic       master;
	} gwsl_rise_t;

	typedef struct packed {
		logic [7:0] word;
	} gwsl_fall_t;

	gwsl_rise_t rise_r;
	gwsl_rise_t rise_nxt;
	gwsl_fall_t fall_r;
	gwsl_fall_t fall_nxt;

	always_comb begin
		rise_nxt = rise_r;
		if (!gain_load_enable_n) begin
			rise_nxt.master = serial_gain_data;
		end
	end

	always_ff @(posedge link_sclk or negedge rst_n) begin
		if (!rst_n) begin
			rise_r <= '0;
		end else begin
			rise_r <= rise_nxt;
		end
	end

	always_comb begin
		fall_nxt = fall_r;
		if (!gain_load_enable_n) begin
			// Oldest bit falls off the top, so the last eight remain
			fall_nxt.word = {fall_r.word[gwsl_pkg::WORD_W-2:0], rise_r.master};
		end
	end

	// Second edge of the same link clock; kept apart from the rising-edge state
	always_ff @(negedge link_sclk or negedge rst_n) begin
		if (!rst_n) begin
			fall_r <= '0;
		end else begin
			fall_r <= fall_nxt;
		end
	end

	// Crossing into the system clock
	logic [2:0] pins_sync;
	logic [7:0] word_sync;

	// Word is stable from its last shift until after the enable rises
	gwsl_sync2 #(
		.W    (gwsl_pkg::WORD_W),
		.INIT (gwsl_pkg::WORD_RESET)
	) u_word_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     (fall_r.word),
		.q     (word_sync)
	);

	gwsl_sync2 #(
		.W    (gwsl_pkg::PIN_W),
		.INIT (gwsl_pkg::PIN_RESET)
	) u_pin_sync (
		.clock (clock),
		.rst_n (rst_n),
		.d     ({transmit_gate, sleep_n, gain_load_enable_n}),
		.q     (pins_sync)
	);

	logic load_en_n_s;
	logic sleep_n_s;
	logic txgate_s;

	assign load_en_n_s = pins_sync[gwsl_pkg::PIN_LOAD];
	assign sleep_n_s   = pins_sync[gwsl_pkg::PIN_SLEEP];
	assign txgate_s    = pins_sync[gwsl_pkg::PIN_TXGATE];

	// System clock domain state
	typedef struct packed {
		logic        load_prev;
		logic        load_pend;
		logic        dp_active;
		logic        dp_write;
		logic [7:0]  dp_addr;
		logic [5:0]  code;
		logic [7:0]  half_db;
		logic [7:0]  last_word;
		logic [15:0] load_count;
		logic        hiz;
		logic        powered;
		logic        tx;
		logic [31:0] rdata;
		logic        readyout;
		logic        resp;
	} gwsl_state_t;

	gwsl_state_t st_r;
	gwsl_state_t st_nxt;

	logic        load_rise;
	logic        addr_phase;
	logic [7:0]  addr_off;
	logic [31:0] status_word;
	logic [5:0]  new_code;

	assign load_rise   = load_en_n_s && !st_r.load_prev;
	assign addr_phase  = hsel && hready && (htrans == gwsl_pkg::HTRANS_NONSEQ);
	assign addr_off    = {haddr[gwsl_pkg::ADDR_MSB:gwsl_pkg::ADDR_LSB], 2'h0};

	always_comb begin
		status_word = gwsl_pkg::DATA_ZERO;
		status_word[gwsl_pkg::ST_CODE_LSB +: gwsl_pkg::CODE_W] = st_r.code;
		status_word[gwsl_pkg::ST_WORD_LSB +: gwsl_pkg::WORD_W] = st_r.last_word;
		status_word[gwsl_pkg::ST_POWERED] = st_r.powered;
		status_word[gwsl_pkg::ST_TX]      = st_r.tx;
		status_word[gwsl_pkg::ST_LOADING] = !load_en_n_s;
	end

	always_comb begin
		st_nxt           = st_r;
		st_nxt.load_prev = load_en_n_s;
		st_nxt.load_pend = load_rise;
		st_nxt.readyout  = 1'b1;
		st_nxt.resp      = 1'b0;
		new_code         = st_r.code;

		// Data phase of a write: gain register takes a software code
		if (st_r.dp_active && st_r.dp_write && st_r.dp_addr == gwsl_pkg::ADDR_GAIN) begin
			new_code = clamp_code(hwdata[gwsl_pkg::WORD_W-1:0]);
		end

		// Serial load wins over a software write in the same cycle
		// Taken a cycle after the rise, so a late-resolving word bit has settled
		if (st_r.load_pend) begin
			new_code          = clamp_code(word_sync);
			st_nxt.last_word  = word_sync;
			st_nxt.load_count = 16'(st_r.load_count + 16'h0001);
		end

		// Without a rise or a gain register write the applied code holds while bits shift in
		st_nxt.code    = new_code;
		st_nxt.half_db = half_db(new_code);

		st_nxt.powered = sleep_n_s;
		st_nxt.hiz     = !sleep_n_s;
		st_nxt.tx      = sleep_n_s && txgate_s;

		// Address phase: capture for the write, prepare read data now
		st_nxt.dp_active = 1'b0;
		st_nxt.dp_write  = 1'b0;
		if (hready) begin
			st_nxt.rdata = gwsl_pkg::DATA_ZERO;
		end
		if (addr_phase) begin
			st_nxt.dp_active = (hsize == gwsl_pkg::HSIZE_WORD);
			st_nxt.dp_write  = hwrite;
			st_nxt.dp_addr   = addr_off;
			if (!hwrite) begin
				unique case (addr_off)
					gwsl_pkg::ADDR_GAIN: begin
						st_nxt.rdata = {24'h00_0000, 2'h0, st_r.code};
					end
					gwsl_pkg::ADDR_STATUS: begin
						st_nxt.rdata = status_word;
					end
					gwsl_pkg::ADDR_COUNT: begin
						st_nxt.rdata = {16'h0000, st_r.load_count};
					end
					default: begin
						st_nxt.rdata = gwsl_pkg::DATA_ZERO;
					end
				endcase
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r.load_prev  <= 1'b1;
			st_r.load_pend  <= 1'b0;
			st_r.dp_active  <= 1'b0;
			st_r.dp_write   <= 1'b0;
			st_r.dp_addr    <= 8'h00;
			st_r.code       <= gwsl_pkg::CODE_RESET;
			st_r.half_db    <= gwsl_pkg::HALF_DB_RESET;
			st_r.last_word  <= gwsl_pkg::WORD_RESET;
			st_r.load_count <= 16'h0000;
			st_r.hiz        <= 1'b0;
			st_r.powered    <= 1'b1;
			st_r.tx         <= 1'b1;
			st_r.rdata      <= gwsl_pkg::DATA_ZERO;
			st_r.readyout   <= 1'b1;
			st_r.resp       <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign hrdata       = st_r.rdata;
	assign hreadyout    = st_r.readyout;
	assign hresp        = st_r.resp;
	assign gain_code    = st_r.code;
	assign gain_half_db = st_r.half_db;
	assign out_hiz      = st_r.hiz;
	assign powered_up   = st_r.powered;
	assign tx_active    = st_r.tx;
endmodule

// ==== gwsl_sync.sv ====
// Two-flop synchroniser for single pins and for words that stay quiet while crossing.
// Assumes an asynchronous active-low reset in the destination clock domain.
`timescale 1ns/1ps
module gwsl_sync2 #(
	parameter int          W     = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clock,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} gwsl_sync_t;

	gwsl_sync_t st_r;
	gwsl_sync_t st_nxt;

	always_comb begin
		st_nxt.s1 = d;
		st_nxt.s2 = st_r.s1;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= {INIT, INIT};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign q = st_r.s2;
endmodule

// ==== gwsl_chk.sv ====
// Port checker for the gain loader.
// Bound from tb_top; all in the system clock domain.
`timescale 1ns/1ps
module gwsl_chk (
	input wire logic       clock,
	input wire logic       rst_n,
	input wire logic       gain_load_enable_n,
	input wire logic       sleep_n,
	input wire logic       transmit_gate,
	input wire logic       hwrite,
	input wire logic       hreadyout,
	input wire logic       hresp,
	input wire logic [5:0] gain_code,
	input wire logic [7:0] gain_half_db,
	input wire logic       out_hiz,
	input wire logic       powered_up,
	input wire logic       tx_active
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_n);
	a_code_max: assert property (gain_code <= 6'h3c)
		else $error("gain code above 60");
	a_half_db: assert property (
		gain_half_db == {1'b0, gain_code, 1'b0} - 8'h35)
		else $error("half dB gain wrong for code");
	a_gain_hold: assert property (
		!gain_load_enable_n [*6] ##0 !hwrite [*2] |-> $stable(gain_code))
		else $error("gain moved while loading");
	a_sleep_hiz: assert property (!sleep_n [*5] |-> out_hiz && !powered_up)
		else $error("asleep but not high impedance");
	a_wake_up: assert property (sleep_n [*5] |-> powered_up && !out_hiz)
		else $error("awake but powered down");
	a_tx_on: assert property ((sleep_n && transmit_gate) [*5] |-> tx_active)
		else $error("transmission not enabled");
	a_tx_off: assert property (!transmit_gate [*5] |-> !tx_active)
		else $error("transmission not disabled");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus not ready or not OKAY");
endmodule

// ==== gwsl_host.sv ====
// Host model driving serial clock, load enable and data.
// Serial clock period 30 ns; it stands low between frames.
`timescale 1ns/1ps
module gwsl_host (
	output logic link_sclk,
	output logic gain_load_enable_n,
	output logic serial_gain_data
);
	initial begin
		link_sclk = 1'b0;
		gain_load_enable_n = 1'b1;
		serial_gain_data = 1'b0;
	end
	// Ten bits, so the two leading ones must drop out
	task automatic send(input logic [9:0] bits);
		gain_load_enable_n = 1'b0;
		#20;
		for (int i = 9; i >= 0; i--) begin
			serial_gain_data = bits[i];
			#7.5 link_sclk = 1'b1;
			#15 link_sclk = 1'b0;
			#7.5;
		end
		gain_load_enable_n = 1'b1;
		serial_gain_data = ~serial_gain_data;
	endtask
	// Clocks with the enable high must be ignored
	task automatic stray;
		repeat (4) begin
			serial_gain_data = ~serial_gain_data;
			#15 link_sclk = 1'b1;
			#15 link_sclk = 1'b0;
		end
	endtask
endmodule

// ==== tb_top.sv ====
// Bench for gwsl_loader: AHB-Lite tasks, serial loads via gwsl_host, power pins.
// Single slave, so hreadyout feeds hready; checker bound at the foot.
`timescale 1ns/1ps
module tb_top;
	logic        clock;
	logic        rst_n;
	logic        link_sclk;
	logic        gain_load_enable_n;
	logic        serial_gain_data;
	logic        sleep_n;
	logic        transmit_gate;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hreadyout;
	logic        hresp;
	logic [5:0]  gain_code;
	logic [7:0]  gain_half_db;
	logic        out_hiz;
	logic        powered_up;
	logic        tx_active;
	logic [31:0] rd;
	logic [5:0]  ec;
	logic [1:0]  pv;
	logic [7:0]  words [7] = '{8'h4b, 8'h3c, 8'h3d, 8'h3e, 8'h3f, 8'h01, 8'hc5};
	int          n_mismatch;
	int          num_checks;

	gwsl_host host (.link_sclk(link_sclk), .gain_load_enable_n(gain_load_enable_n),
		.serial_gain_data(serial_gain_data));
	gwsl_loader dut (
		.clock              (clock),
		.rst_n              (rst_n),
		.link_sclk          (link_sclk),
		.gain_load_enable_n (gain_load_enable_n),
		.serial_gain_data   (serial_gain_data),
		.sleep_n            (sleep_n),
		.transmit_gate      (transmit_gate),
		.hsel               (hsel),
		.haddr              (haddr),
		.htrans             (htrans),
		.hwrite             (hwrite),
		.hsize              (hsize),
		.hwdata             (hwdata),
		.hready             (hreadyout),
		.hrdata             (hrdata),
		.hreadyout          (hreadyout),
		.hresp              (hresp),
		.gain_code          (gain_code),
		.gain_half_db       (gain_half_db),
		.out_hiz            (out_hiz),
		.powered_up         (powered_up),
		.tx_active          (tx_active)
	);

	always #2 clock = ~clock;

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic wait_rdy;
		int k = 0;
		@(posedge clock);
		while (hreadyout !== 1'b1) begin
			k++;
			if (k > 100) begin
				n_mismatch++;
				give_verdict;
			end
			@(posedge clock);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= 3'h2;
		wait_rdy;
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy;
		rd = hrdata;
	endtask

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		sleep_n = 1'b1;
		transmit_gate = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		ahb(1'b0, 8'h00, 32'h0);
		check("reset gain", rd, 32'h1);
		check("reset half dB", {24'h0, gain_half_db}, 32'hcd);
		$display("reset test done");
		foreach (words[i]) begin
			ec = (words[i][5:0] > 6'h3c) ? 6'h3c : words[i][5:0];
			host.send({2'b11, words[i]});
			repeat (8) @(posedge clock);
			check("gain code", {26'h0, gain_code}, {26'h0, ec});
			check("half dB", {24'h0, gain_half_db}, {24'h0, {1'b0, ec, 1'b0} - 8'h35});
			ahb(1'b0, 8'h04, 32'h0);
			check("serial word", {24'h0, rd[15:8]}, {24'h0, words[i]});
		end
		host.stray;
		repeat (8) @(posedge clock);
		ahb(1'b0, 8'h04, 32'h0);
		check("word after stray", {24'h0, rd[15:8]}, 32'hc5);
		check("code after stray", {26'h0, gain_code}, 32'h5);
		ahb(1'b0, 8'h08, 32'h0);
		check("load count", rd, 32'h7);
		$display("serial test done");
		ahb(1'b1, 8'h00, 32'h3f);
		ahb(1'b1, 8'h10, 32'h11);
		ahb(1'b0, 8'h10, 32'h0);
		check("unmapped read", rd, 32'h0);
		ahb(1'b0, 8'h00, 32'h0);
		check("written gain", rd, 32'h3c);
		$display("register test done");
		for (int i = 3; i >= 0; i--) begin
			pv = 2'(i);
			sleep_n <= pv[1];
			transmit_gate <= pv[0];
			repeat (6) @(posedge clock);
			check("powered", {31'h0, powered_up}, {31'h0, pv[1]});
			check("hi-z", {31'h0, out_hiz}, {31'h0, ~pv[1]});
			check("transmit", {31'h0, tx_active}, {31'h0, pv[1] & pv[0]});
			ahb(1'b0, 8'h04, 32'h0);
			check("status pins", {30'h0, rd[17:16]}, {30'h0, pv[1] & pv[0], pv[1]});
		end
		$display("power test done");
		give_verdict;
	end
endmodule

bind gwsl_loader gwsl_chk chk (
	.clock              (clock),
	.rst_n              (rst_n),
	.gain_load_enable_n (gain_load_enable_n),
	.sleep_n            (sleep_n),
	.transmit_gate      (transmit_gate),
	.hwrite             (hwrite),
	.hreadyout          (hreadyout),
	.hresp              (hresp),
	.gain_code          (gain_code),
	.gain_half_db       (gain_half_db),
	.out_hiz            (out_hiz),
	.powered_up         (powered_up),
	.tx_active          (tx_active)
);
